// [logic/tcp_timer_top.sv]
// Waveform side of a 16-bit timer: compares, forced levels,
// one-pulse and modulation modes, with an APB register slave.
// Assumes pins synchronous to clk; one wait state per APB access.
`timescale 1ns/1ps
module tcp_timer_top
  import tcp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic firstCapturePin,
  input wire logic secondCapturePin,
  input wire logic extClkPin,
  output logic firstCompareOutputPin,
  output logic firstPinSelect,
  output logic secondCompareOutputPin,
  output logic secondPinSelect,
  output logic timerIrq
);
  // Flag and arm vectors: [0] first_capture_flag, [1] second_capture_flag, [2] first_compare_flag, [3] second_compare_flag
  typedef struct packed {
    logic [7:0] ctl1;
    logic [7:0] ctl2;
    logic [15:0] cnt;
    logic [15:0] oc1;
    logic [15:0] oc2;
    logic [15:0] ic1;
    logic [15:0] ic2;
    logic [1:0] ocEn;
    logic [3:0] flg;
    logic [3:0] arm;
    logic fresh;
    logic pin1;
    logic pin2;
    logic sel1;
    logic sel2;
    logic irq;
    logic ready;
    logic err;
    logic [31:0] rdata;
  } tcp_state_t;

  tcp_state_t q;
  tcp_state_t d;
  logic [1:0] rstSyncQ;
  logic rstN;
  logic tick;
  logic extEdge;
  logic icEdge1;
  logic icEdge2;
  logic pwmMode;
  logic opmMode;
  logic normMode;
  logic div2;
  logic moment;
  logic evOc1;
  logic evOc2;
  logic acc;
  logic wrAcc;
  logic rdStat;
  logic reload;
  logic [3:0] lowAcc;
  logic [3:0] setFlg;
  logic [3:0] clrFlg;
  logic [3:0] shownFlg;
  logic [7:0] statByte;
  logic [7:0] rdByte;
  logic known;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSyncQ <= 2'h0;
    end else begin
      rstSyncQ <= {rstSyncQ[0], 1'b1};
    end
  end
  assign rstN = rstSyncQ[1];

  tcp_edge_detect uExt (
    .clk(clk),
    .rstN(rstN),
    .pinIn(extClkPin),
    .riseSel(q.ctl2[C2_EXEDG]),
    .edgePulse(extEdge)
  );
  tcp_edge_detect uIc1 (
    .clk(clk),
    .rstN(rstN),
    .pinIn(firstCapturePin),
    .riseSel(q.ctl1[C1_FIRST_CAPTURE_EDGE_SELECT]),
    .edgePulse(icEdge1)
  );
  tcp_edge_detect uIc2 (
    .clk(clk),
    .rstN(rstN),
    .pinIn(secondCapturePin),
    .riseSel(q.ctl2[C2_IEDG2]),
    .edgePulse(icEdge2)
  );
  tcp_prescale uPre (
    .clk(clk),
    .rstN(rstN),
    .clkSel(q.ctl2[C2_CC1:C2_CC0]),
    .extEdge(extEdge),
    .tick(tick)
  );

  assign pwmMode = q.ctl2[C2_PWM];
  assign opmMode = q.ctl2[C2_OPM] & ~pwmMode;
  assign normMode = ~q.ctl2[C2_OPM] & ~pwmMode;
  assign div2 = (q.ctl2[C2_CC1:C2_CC0] == CC_DIV2);
  // At /2 the match is taken the cycle after the count changes, so the
  // flag lands mid-count; otherwise at the tick, landing on count+1.
  assign moment = div2 ? q.fresh : tick;
  assign evOc1 = moment & q.ocEn[0] & (q.cnt == q.oc1);
  assign evOc2 = moment & q.ocEn[1] & (q.cnt == q.oc2);
  assign reload = (opmMode & icEdge1) | (pwmMode & evOc2);

  assign acc = psel & penable & q.ready;
  assign wrAcc = acc & pwrite;
  assign rdStat = acc & ~pwrite & (paddr == OFS_STAT);
  assign lowAcc = {acc & (paddr == OFS_OC2L), acc & (paddr == OFS_OC1L),
                   acc & (paddr == OFS_IC2L), acc & (paddr == OFS_IC1L)};
  assign clrFlg = lowAcc & q.arm;
  // Arm only what the status read returned: a flag set during the wait
  // state was never seen by software and must not be cleared unseen
  assign shownFlg = {q.rdata[ST_SECOND_COMPARE_FLAG], q.rdata[ST_FIRST_COMPARE_FLAG],
                     q.rdata[ST_SECOND_CAPTURE_FLAG], q.rdata[ST_FIRST_CAPTURE_FLAG]} & q.flg;

  always_comb begin
    setFlg = 4'h0;
    setFlg[0] = (normMode & icEdge1) | (opmMode & icEdge1)
              | (pwmMode & evOc2);
    setFlg[1] = icEdge2;
    setFlg[2] = normMode & evOc1;
    setFlg[3] = ~pwmMode & evOc2;
  end

  always_comb begin
    statByte = 8'h00;
    statByte[ST_FIRST_CAPTURE_FLAG] = q.flg[0];
    statByte[ST_SECOND_CAPTURE_FLAG] = q.flg[1];
    statByte[ST_FIRST_COMPARE_FLAG] = q.flg[2];
    statByte[ST_SECOND_COMPARE_FLAG] = q.flg[3];
    known = 1'b1;
    case (paddr)
      OFS_CTL1: rdByte = q.ctl1;
      OFS_CTL2: rdByte = q.ctl2;
      OFS_STAT: rdByte = statByte;
      OFS_IC1H: rdByte = q.ic1[15:8];
      OFS_IC1L: rdByte = q.ic1[7:0];
      OFS_OC1H: rdByte = q.oc1[15:8];
      OFS_OC1L: rdByte = q.oc1[7:0];
      OFS_CNTH: rdByte = q.cnt[15:8];
      OFS_CNTL: rdByte = q.cnt[7:0];
      OFS_IC2H: rdByte = q.ic2[15:8];
      OFS_IC2L: rdByte = q.ic2[7:0];
      OFS_OC2H: rdByte = q.oc2[15:8];
      OFS_OC2L: rdByte = q.oc2[7:0];
      default: begin
        rdByte = 8'h00;
        known = 1'b0;
      end
    endcase
  end

  always_comb begin
    d = q;
    d.fresh = tick;
    d.ready = 1'b0;
    if (psel && penable && !q.ready) begin
      d.ready = 1'b1;
      d.err = ~known;
      d.rdata = known ? {24'h000000, rdByte} : 32'h00000000;
    end
    if (wrAcc) begin
      case (paddr)
        OFS_CTL1: d.ctl1 = pwdata[7:0];
        OFS_CTL2: d.ctl2 = pwdata[7:0];
        OFS_OC1H: begin
          d.oc1[15:8] = pwdata[7:0];
          d.ocEn[0] = 1'b0;
        end
        OFS_OC1L: begin
          d.oc1[7:0] = pwdata[7:0];
          d.ocEn[0] = 1'b1;
        end
        OFS_OC2H: begin
          d.oc2[15:8] = pwdata[7:0];
          d.ocEn[1] = 1'b0;
        end
        OFS_OC2L: begin
          d.oc2[7:0] = pwdata[7:0];
          d.ocEn[1] = 1'b1;
        end
        default: d.err = q.err;
      endcase
    end
    // Set wins over a clear landing in the same cycle
    d.flg = setFlg | (q.flg & ~clrFlg);
    d.arm = (q.arm & ~clrFlg) | (rdStat ? shownFlg : 4'h0);
    if (reload) begin
      d.cnt = CNT_RELOAD;
    end else if (tick) begin
      d.cnt = q.cnt + 16'h0001;
    end
    if (opmMode && icEdge1) begin
      d.ic1 = IC_PULSE_VAL;
    end else if (normMode && icEdge1) begin
      d.ic1 = q.cnt;
    end
    if (icEdge2) begin
      d.ic2 = q.cnt;
    end
    // Pin latches only follow while the alternate function is selected
    if (q.ctl2[C2_FIRST_COMPARE_PIN_ENABLE]) begin
      if (normMode) begin
        if (evOc1 || q.ctl1[C1_FOLV1]) begin
          d.pin1 = q.ctl1[C1_AFTER_LVL];
        end
      end else if (opmMode) begin
        if (icEdge1) begin
          d.pin1 = q.ctl1[C1_PULSE_LVL];
        end else if (evOc1) begin
          d.pin1 = q.ctl1[C1_AFTER_LVL];
        end
      end else begin
        if (evOc2) begin
          d.pin1 = q.ctl1[C1_PULSE_LVL];
        end else if (evOc1) begin
          d.pin1 = q.ctl1[C1_AFTER_LVL];
        end
      end
    end
    if (q.ctl2[C2_OC2E] && normMode) begin
      if (evOc2 || q.ctl1[C1_FOLV2]) begin
        d.pin2 = q.ctl1[C1_PULSE_LVL];
      end
    end
    d.sel1 = q.ctl2[C2_FIRST_COMPARE_PIN_ENABLE];
    d.sel2 = q.ctl2[C2_OC2E] & normMode;
    d.irq = (q.ctl1[C1_CAPTURE_INTERRUPT_ENABLE] & |q.flg[1:0])
          | (q.ctl1[C1_COMPARE_INTERRUPT_ENABLE] & |q.flg[3:2]);
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      q <= '0;
      q.ctl1 <= CTL_RESET;
      q.ctl2 <= CTL_RESET;
      q.cnt <= CNT_RESET;
      q.oc1 <= OC_RESET;
      q.oc2 <= OC_RESET;
      q.ocEn <= 2'h3;
      q.pin1 <= 1'b0;
      q.pin2 <= 1'b0;
    end else begin
      q <= d;
    end
  end

  assign prdata = q.rdata;
  assign pready = q.ready;
  assign pslverr = q.err;
  assign firstCompareOutputPin = q.pin1;
  assign firstPinSelect = q.sel1;
  assign secondCompareOutputPin = q.pin2;
  assign secondPinSelect = q.sel2;
  assign timerIrq = q.irq;

  high_inhibit_a: assert property (
    @(posedge clk) disable iff (!rstN)
    (wrAcc && paddr == OFS_OC1H) |=> !evOc1 && !q.ocEn[0])
    else $error("compare one matched after high byte write");
  div_two_a: assert property (
    @(posedge clk) disable iff (!rstN)
    (evOc1 && div2 && normMode && !reload) |=> q.flg[2] && q.cnt == $past(q.oc1))
    else $error("divide-by-two flag not set at count equal");
  div_other_a: assert property (
    @(posedge clk) disable iff (!rstN)
    (evOc1 && !div2 && normMode && !reload)
    |=> q.flg[2] && q.cnt == $past(q.oc1) + 16'h0001)
    else $error("slow clock flag not set at count plus one");
  force_level_a: assert property (
    @(posedge clk) disable iff (!rstN)
    (normMode && q.ctl1[C1_FOLV1] && q.ctl2[C2_FIRST_COMPARE_PIN_ENABLE] && !evOc1)
    |=> q.pin1 == $past(q.ctl1[C1_AFTER_LVL]) && !$rose(q.flg[2]))
    else $error("forced level not copied or flag raised");
  pulse_start_a: assert property (
    @(posedge clk) disable iff (!rstN)
    (opmMode && icEdge1 && q.ctl2[C2_FIRST_COMPARE_PIN_ENABLE])
    |=> q.cnt == CNT_RELOAD && q.ic1 == IC_PULSE_VAL && q.flg[0]
        && q.pin1 == $past(q.ctl1[C1_PULSE_LVL]))
    else $error("one-pulse trigger effects missing");
  pulse_no_ocf_a: assert property (
    @(posedge clk) disable iff (!rstN)
    opmMode && $past(opmMode) |-> !$rose(q.flg[2]))
    else $error("first compare flag set in one-pulse mode");
  pwm_reload_a: assert property (
    @(posedge clk) disable iff (!rstN)
    (pwmMode && evOc2) |=> q.cnt == CNT_RELOAD && q.flg[0])
    else $error("modulation period reload missing");
  pwm_no_flag_a: assert property (
    @(posedge clk) disable iff (!rstN)
    pwmMode && $past(pwmMode) |-> !$rose(q.flg[2]) && !$rose(q.flg[3]))
    else $error("compare flag set in modulation mode");
  count_step_a: assert property (
    @(posedge clk) disable iff (!rstN)
    (tick && !reload) |=> q.cnt == $past(q.cnt) + 16'h0001)
    else $error("counter did not advance on tick");
  pwm_pin_levels_a: assert property (
    @(posedge clk) disable iff (!rstN)
    (pwmMode && q.ctl2[C2_FIRST_COMPARE_PIN_ENABLE] && evOc1 && !evOc2)
    |=> q.pin1 == $past(q.ctl1[C1_AFTER_LVL]))
    else $error("modulation first match level wrong");
  pwm_cap_ignore_a: assert property (
    @(posedge clk) disable iff (!rstN)
    (pwmMode && icEdge1) |=> q.ic1 == $past(q.ic1))
    else $error("first capture taken in modulation mode");
  second_pin_idle_a: assert property (
    @(posedge clk) disable iff (!rstN)
    !normMode |=> !q.sel2 && $stable(q.pin2))
    else $error("second pin driven outside normal mode");
endmodule

// [common/tcp_pkg.sv]
// Constants shared by the compare, pulse and modulation timer.
// Assumes byte addresses on an 8-bit APB address bus.
package tcp_pkg;
  localparam logic [7:0] OFS_CTL1 = 8'h00;
  localparam logic [7:0] OFS_CTL2 = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_IC1H = 8'h0c;
  localparam logic [7:0] OFS_IC1L = 8'h10;
  localparam logic [7:0] OFS_OC1H = 8'h14;
  localparam logic [7:0] OFS_OC1L = 8'h18;
  localparam logic [7:0] OFS_CNTH = 8'h1c;
  localparam logic [7:0] OFS_CNTL = 8'h20;
  localparam logic [7:0] OFS_IC2H = 8'h24;
  localparam logic [7:0] OFS_IC2L = 8'h28;
  localparam logic [7:0] OFS_OC2H = 8'h2c;
  localparam logic [7:0] OFS_OC2L = 8'h30;
  // Control one fields
  localparam int C1_CAPTURE_INTERRUPT_ENABLE = 7;
  localparam int C1_COMPARE_INTERRUPT_ENABLE = 6;
  localparam int C1_FOLV2 = 4;
  localparam int C1_FOLV1 = 3;
  localparam int C1_PULSE_LVL = 2;
  localparam int C1_FIRST_CAPTURE_EDGE_SELECT = 1;
  localparam int C1_AFTER_LVL = 0;
  // Control two fields
  localparam int C2_FIRST_COMPARE_PIN_ENABLE = 7;
  localparam int C2_OC2E = 6;
  localparam int C2_OPM = 5;
  localparam int C2_PWM = 4;
  localparam int C2_CC1 = 3;
  localparam int C2_CC0 = 2;
  localparam int C2_IEDG2 = 1;
  localparam int C2_EXEDG = 0;
  // Status fields
  localparam int ST_FIRST_CAPTURE_FLAG = 7;
  localparam int ST_FIRST_COMPARE_FLAG = 6;
  localparam int ST_SECOND_CAPTURE_FLAG = 4;
  localparam int ST_SECOND_COMPARE_FLAG = 3;
  // Timer clock select encodings
  localparam logic [1:0] CC_DIV4 = 2'h0;
  localparam logic [1:0] CC_DIV2 = 2'h1;
  localparam logic [1:0] CC_DIV8 = 2'h2;
  localparam logic [1:0] CC_EXT = 2'h3;
  // Reset and reload values
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [15:0] OC_RESET = 16'h8000;
  localparam logic [15:0] CNT_RESET = 16'hfffc;
  localparam logic [15:0] CNT_RELOAD = 16'hfffc;
  localparam logic [15:0] IC_PULSE_VAL = 16'hfffd;
endpackage

// [logic/tcp_edge_detect.sv]
// Edge detector for one timer pin, selectable rising or falling.
// Assumes the pin is already synchronous to clk.
`timescale 1ns/1ps
module tcp_edge_detect
  import tcp_pkg::*;
(
  input wire logic clk,
  input wire logic rstN,
  input wire logic pinIn,
  input wire logic riseSel,
  output logic edgePulse
);
  typedef struct packed {
    logic prev;
  } tcp_edge_t;
  tcp_edge_t q;
  tcp_edge_t d;

  always_comb begin
    d = q;
    d.prev = pinIn;
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign edgePulse = riseSel ? (pinIn & ~q.prev) : (~pinIn & q.prev);
endmodule

// [logic/tcp_prescale.sv]
// Timer clock generator: one-cycle tick at clk/2, /4, /8 or per
// external edge. Assumes extEdge is a one-cycle pulse.
`timescale 1ns/1ps
module tcp_prescale
  import tcp_pkg::*;
(
  input wire logic clk,
  input wire logic rstN,
  input wire logic [1:0] clkSel,
  input wire logic extEdge,
  output logic tick
);
  typedef struct packed {
    logic [2:0] div;
  } tcp_pre_t;
  tcp_pre_t q;
  tcp_pre_t d;

  always_comb begin
    d = q;
    d.div = q.div + 3'h1;
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  always_comb begin
    case (clkSel)
      CC_DIV2: tick = q.div[0];
      CC_DIV4: tick = &q.div[1:0];
      CC_DIV8: tick = &q.div;
      default: tick = extEdge;
    endcase
  end
endmodule

// [test/tcp_far_side.sv]
// Far side model: trigger source on the first capture pin and a
// free-running external timer clock; the second capture pin rests low.
// Assumes the bench raises fire for one clk to ask for a trigger.
`timescale 1ns/1ps
module tcp_far_side (
  input wire logic clk,
  input wire logic fire,
  output logic firstCapturePin,
  output logic secondCapturePin,
  output logic extClkPin
);
  int n = 0;
  int hold = 0;

  initial begin
    firstCapturePin = 1'b0;
    secondCapturePin = 1'b0;
    extClkPin = 1'b0;
  end

  // External clock at clk/8, well under the clk/4 ceiling
  always @(posedge clk) begin
    n <= n + 1;
    extClkPin <= n[2];
    hold <= fire ? 6 : ((hold != 0) ? hold - 1 : 0);
    firstCapturePin <= fire || (hold != 0);
  end
endmodule

// [test/testbench.sv]
// Self-checking bench for the compare, one-pulse and modulation timer.
// Assumes one APB wait state and pins registered on clk.
`timescale 1ns/1ps
module testbench;
  import tcp_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic fire = 1'b0;
  logic [31:0] prdata, rdv;
  logic pready, pslverr, errv, cap1, cap2, extClk;
  logic pin1, sel1, pin2, sel2, irq;
  logic [15:0] v1, v2, cnt;
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;
  int t0, t1, t2, p;

  tcp_timer_top dut (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .firstCapturePin(cap1), .secondCapturePin(cap2), .extClkPin(extClk),
    .firstCompareOutputPin(pin1), .firstPinSelect(sel1),
    .secondCompareOutputPin(pin2), .secondPinSelect(sel2),
    .timerIrq(irq));
  tcp_far_side far (.clk(clk), .fire(fire), .firstCapturePin(cap1),
    .secondCapturePin(cap2), .extClkPin(extClk));

  initial begin
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Measured clk counts against a window
  task automatic chkr(input int got, input int lo, input int hi);
    total_checks++;
    if (got < lo || got > hi) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, lo);
    end
  endtask

  // Idle cycle at the end so the next setup never lands in this step
  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [7:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    // Only pready or the bench timeout ends this wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 8'h00);
  endtask

  task automatic setoc(input logic [7:0] ah, input logic [15:0] v);
    apb(1'b1, ah, v[15:8]);
    apb(1'b1, ah + 8'h04, v[7:0]);
  endtask

  task automatic getcnt(output logic [15:0] v);
    rd(OFS_CNTH);
    v[15:8] = rdv[7:0];
    rd(OFS_CNTL);
    v[7:0] = rdv[7:0];
    // High byte may have stepped between the two reads
    rd(OFS_CNTH);
    if (rdv[7:0] != v[15:8]) begin
      v[15:8] = rdv[7:0];
      v[7:0] = 8'h00;
    end
  endtask

  task automatic waitpin(input logic v, output int t);
    int k;
    k = 0;
    while (pin1 !== v && k < 3000) begin
      @(posedge clk);
      k++;
    end
    t = cyc;
    if (k >= 3000) begin
      n_fail++;
      test_done();
    end
  endtask

  initial begin
    void'($urandom(87493));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk({31'h0, pin1}, 32'h0);
    chk({31'h0, pin2}, 32'h0);
    rd(OFS_OC1H);
    chk(rdv, 32'h80);
    rd(8'hfc);
    chk({31'h0, errv}, 32'h1);
    apb(1'b1, OFS_CTL2, 8'h80);
    apb(1'b1, OFS_CTL1, 8'h49);
    rd(OFS_STAT);
    chk(rdv, 32'h0);
    chk({31'h0, pin1}, 32'h1);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, OFS_CTL2, 8'ha0);
    apb(1'b1, OFS_CTL1, 8'h08);
    rd(OFS_STAT);
    chk({31'h0, pin1}, 32'h1);
    // Pin disabled, clock/2: matching held off between the two bytes
    apb(1'b1, OFS_CTL2, 8'h04);
    apb(1'b1, OFS_CTL1, 8'h40);
    getcnt(cnt);
    cnt = cnt + 16'h003c;
    apb(1'b1, OFS_OC1L, cnt[7:0]);
    apb(1'b1, OFS_OC1H, cnt[15:8]);
    repeat (200) @(posedge clk);
    rd(OFS_STAT);
    chk(rdv, 32'h0);
    getcnt(cnt);
    setoc(OFS_OC1H, cnt + 16'h003c);
    repeat (200) @(posedge clk);
    rd(OFS_STAT);
    chk(rdv, 32'h40);
    chk({31'h0, pin1}, 32'h1);
    chk({31'h0, sel1}, 32'h0);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, OFS_CTL2, 8'h80);
    apb(1'b1, OFS_CTL1, 8'h08);
    // One pulse at clock/2, 0x24 ticks long
    apb(1'b1, OFS_CTL2, 8'ha4);
    apb(1'b1, OFS_CTL1, 8'h86);
    setoc(OFS_OC1H, 16'h0020);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    waitpin(1'b1, t0);
    waitpin(1'b0, t1);
    chkr(t1 - t0, 70, 76);
    chk({31'h0, irq}, 32'h1);
    rd(OFS_STAT);
    chk(rdv, 32'h80);
    rd(OFS_IC1H);
    chk(rdv, 32'hff);
    rd(OFS_IC1L);
    chk(rdv, 32'hfd);
    rd(OFS_STAT);
    chk(rdv, 32'h0);
    // Modulation with the one-pulse bit also set, every clock source
    apb(1'b1, OFS_CTL1, 8'h83);
    for (int c = 0; c < 4; c++) begin
      p = (c == 1) ? 2 : ((c == 0) ? 4 : 8);
      v1 = 16'(2 + $urandom % 8);
      v2 = v1 + 16'(3 + $urandom % 10);
      // Restart the count by a one-pulse trigger before modulation, else
      // a count already past the period would have to wrap first
      apb(1'b1, OFS_CTL2, {4'ha, c[1:0], 2'b00});
      setoc(OFS_OC2H, v2);
      setoc(OFS_OC1H, v1);
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
      apb(1'b1, OFS_CTL2, {4'hb, c[1:0], 2'b00});
      waitpin(1'b0, t0);
      waitpin(1'b1, t0);
      waitpin(1'b0, t1);
      waitpin(1'b1, t2);
      chkr(t1 - t0, (v2 - v1) * p, (v2 - v1) * p);
      chkr(t2 - t0, (v2 + 4) * p, (v2 + 5) * p);
    end
    // Drop flags left by the one-pulse restarts, then let modulation run
    rd(OFS_STAT);
    rd(OFS_OC2L);
    rd(OFS_IC1L);
    repeat (300) @(posedge clk);
    rd(OFS_STAT);
    chk(rdv, 32'h80);
    apb(1'b1, OFS_CTL1, 8'h85);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (300) @(posedge clk);
    t0 = 0;
    repeat (400) begin
      @(posedge clk);
      if (pin1 !== 1'b1) t0++;
    end
    chkr(t0, 0, 0);
    chk({31'h0, irq}, 32'h1);
    test_done();
  end
endmodule
